// *** pkg/nvx_pkg.sv ***
// Purpose: Shared constants and types for the nonvolatile I/O expander register map.
// Assumes: A byte-level serial engine outside this block delivers address, data and stop events.
// Notes: Behaviour
package nvx_pkg;

   localparam int          PINS         = 9;
   localparam int          USER_BYTES   = 64;
   localparam int          ROW_BYTES    = 8;
   localparam int          SCRATCH_N    = 6;
   localparam int          SHADOW_N     = 5;
   localparam int          CLK_MHZ      = 100;
   localparam int          TWR_MS       = 10;
   localparam int          TWR_CYCLES   = TWR_MS * 1000 * CLK_MHZ;

   localparam logic [7:0]  USER_LAST    = 8'h3f;
   localparam logic [7:0]  PULLUP_LO    = 8'hf0;
   localparam logic [7:0]  PULLUP_HI    = 8'hf1;
   localparam logic [7:0]  DRIVE_LO     = 8'hf2;
   localparam logic [7:0]  DRIVE_HI     = 8'hf3;
   localparam logic [7:0]  CONFIG       = 8'hf4;
   localparam logic [7:0]  EXTRA_FIRST  = 8'hf5;
   localparam logic [7:0]  EXTRA_LAST   = 8'hf7;
   localparam logic [7:0]  LEVEL_LO     = 8'hf8;
   localparam logic [7:0]  LEVEL_HI     = 8'hf9;
   localparam logic [7:0]  SCRATCH_FST  = 8'hfa;
   localparam logic [4:0]  ROW_HIGH     = 5'h1e;
   localparam int          SEE_BIT      = 0;

   localparam logic [7:0]  USER_RST     = 8'h00;
   localparam logic [7:0]  PULLUP_RST   = 8'h00;
   localparam logic [7:0]  DRIVE_LO_RST = 8'hff;
   localparam logic [7:0]  DRIVE_HI_RST = 8'h01;
   localparam logic [7:0]  CONFIG_RST   = 8'h00;
   localparam logic [7:0]  SCRATCH_RST  = 8'h00;
   localparam logic [63:0] HIGH_ROW_RST = {8'h00, 8'h00, 8'h00, CONFIG_RST, DRIVE_HI_RST,
                                           DRIVE_LO_RST, PULLUP_RST, PULLUP_RST};

   typedef enum logic [2:0] {
      ST_LOAD   = 3'b001,
      ST_RUN    = 3'b010,
      ST_COMMIT = 3'b100
   } nvx_state_t;

   typedef struct packed {
      logic       addr_set;
      logic       wr;
      logic       rd;
      logic       stop;
      logic [7:0] data;
   } nvx_req_t;

   typedef struct packed {
      logic       rvalid;
      logic [7:0] rdata;
      logic       busy;
   } nvx_rsp_t;

endpackage

// *** core/nvx_regmap.sv ***
// Purpose: Register map of a nine-pin nonvolatile I/O expander with user memory.
// Assumes: Request strobes come one per cycle from a serial byte engine; pins are synchronous.
// Notes: Nonvolatile cells are modelled as flip-flops reset to factory values.
`timescale 1ns/10ps
module nvx_regmap #(
   parameter int TWR_CYC = nvx_pkg::TWR_CYCLES
) (
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire nvx_pkg::nvx_req_t         req,
   output      nvx_pkg::nvx_rsp_t         rsp,
   input  wire logic [nvx_pkg::PINS-1:0]  io_in,
   output      logic [nvx_pkg::PINS-1:0]  io_out,
   output      logic [nvx_pkg::PINS-1:0]  io_oe_n,
   output      logic [nvx_pkg::PINS-1:0]  pullup_en
);
   import nvx_pkg::*;

   typedef struct packed {
      nvx_state_t                       st;
      logic [7:0]                       addr;
      logic [USER_BYTES-1:0][7:0]       user;
      logic [ROW_BYTES-1:0][7:0]        hnv;
      logic [SHADOW_N-1:0][7:0]         shd;
      logic [SCRATCH_N-1:0][7:0]        scr;
      logic [ROW_BYTES-1:0][7:0]        pbuf;
      logic [ROW_BYTES-1:0]             pmask;
      logic [4:0]                       prow;
      logic [31:0]                      cnt;
      nvx_rsp_t                         rsp;
      logic [PINS-1:0]                  iosamp;
      logic [PINS-1:0]                  oen;
      logic [PINS-1:0]                  pu;
   } nvx_regs_t;

   nvx_regs_t s_q;
   nvx_regs_t s_d;

   function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                     input logic [7:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   // Pending user and extra bytes are not visible until committed; writes to 0xf0-0xf4 read back at once from the shadow.
   function automatic logic [7:0] read_byte(input nvx_regs_t s, input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a <= USER_LAST) begin
         v = s.user[a[5:0]];
      end else if (in_range(a, PULLUP_LO, CONFIG)) begin
         v = s.shd[3'(a - PULLUP_LO)];
      end else if (in_range(a, EXTRA_FIRST, EXTRA_LAST)) begin
         v = s.hnv[a[2:0]];
      end else if (a == LEVEL_LO) begin
         v = s.iosamp[7:0];
      end else if (a == LEVEL_HI) begin
         v = {7'h00, s.iosamp[8]};
      end else if (a >= SCRATCH_FST) begin
         v = s.scr[3'(a - SCRATCH_FST)];
      end
      return v;
   endfunction

   always_comb begin
      s_d            = s_q;
      s_d.rsp.rvalid = 1'b0;
      s_d.iosamp     = io_in;
      case (s_q.st)
         ST_LOAD: begin
            // Pins stay released this cycle so no stale factory value is ever driven.
            s_d.shd = s_q.hnv[SHADOW_N-1:0];
            s_d.st  = ST_RUN;
         end
         ST_RUN: begin
            s_d.pu       = {s_q.shd[1][0], s_q.shd[0]};
            s_d.oen      = {s_q.shd[3][0], s_q.shd[2]};
            s_d.rsp.busy = 1'b0;
            if (req.addr_set) begin
               s_d.addr = req.data;
            end else if (req.wr) begin
               if (s_q.pmask == '0) begin
                  s_d.prow = s_q.addr[7:3];
               end
               if (s_q.addr <= USER_LAST) begin
                  s_d.pbuf[s_q.addr[2:0]]  = req.data;
                  s_d.pmask[s_q.addr[2:0]] = 1'b1;
               end else if (in_range(s_q.addr, PULLUP_LO, CONFIG)) begin
                  s_d.shd[3'(s_q.addr - PULLUP_LO)] = req.data;
                  if (!s_q.shd[4][SEE_BIT]) begin
                     s_d.pbuf[s_q.addr[2:0]]  = req.data;
                     s_d.pmask[s_q.addr[2:0]] = 1'b1;
                  end
               end else if (in_range(s_q.addr, EXTRA_FIRST, EXTRA_LAST)) begin
                  s_d.pbuf[s_q.addr[2:0]]  = req.data;
                  s_d.pmask[s_q.addr[2:0]] = 1'b1;
               end else if (s_q.addr >= SCRATCH_FST) begin
                  s_d.scr[3'(s_q.addr - SCRATCH_FST)] = req.data;
               end
               // Reserved, status and other locations fall through untouched.
               s_d.addr = {s_q.addr[7:3], 3'(s_q.addr[2:0] + 3'h1)};
            end else if (req.rd) begin
               s_d.rsp.rdata  = read_byte(s_q, s_q.addr);
               s_d.rsp.rvalid = 1'b1;
               s_d.addr       = 8'(s_q.addr + 8'h01);
            end
            if (req.stop && (s_q.pmask != '0)) begin
               for (int i = 0; i < ROW_BYTES; i++) begin
                  if (s_q.pmask[i]) begin
                     if (s_q.prow == ROW_HIGH) begin
                        s_d.hnv[i] = s_q.pbuf[i];
                     end else begin
                        s_d.user[{s_q.prow[2:0], 3'(i)}] = s_q.pbuf[i];
                     end
                  end
               end
               s_d.pmask    = '0;
               s_d.cnt      = 32'(TWR_CYC - 1);
               s_d.rsp.busy = 1'b1;
               s_d.st       = ST_COMMIT;
            end
         end
         ST_COMMIT: begin
            // The serial engine must refuse its address while busy is high.
            if (s_q.cnt == 32'h0) begin
               s_d.rsp.busy = 1'b0;
               s_d.st       = ST_RUN;
            end else begin
               s_d.cnt = s_q.cnt - 32'h1;
            end
         end
         default: begin
            s_d.st = ST_LOAD;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_q            <= '0;
         s_q.st         <= ST_LOAD;
         s_q.hnv        <= HIGH_ROW_RST;
         s_q.shd        <= HIGH_ROW_RST[SHADOW_N*8-1:0];
         s_q.oen        <= '1;
         s_q.rsp.busy   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign rsp       = s_q.rsp;
   assign io_out    = '0;
   assign io_oe_n   = s_q.oen;
   assign pullup_en = s_q.pu;

endmodule

// *** bench/nvx_regmap_properties.sv ***
// Purpose: Port checks of the register map.
// Assumes: One clock. Notes: Bound below.
`timescale 1ns/10ps
module nvx_regmap_properties #(parameter int TWR_CYC = 20) (
   input wire logic              clk,
   input wire logic              rstn,
   input wire nvx_pkg::nvx_req_t req,
   input wire nvx_pkg::nvx_rsp_t rsp,
   input wire logic [8:0]        io_oe_n,
   input wire logic [8:0]        pullup_en);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Busy is first seen high one edge after the stop and last seen high TWR_CYC-1 edges later.
   localparam int BUSY_LAST = TWR_CYC - 1;
   wire logic rd_ok = req.rd && !req.addr_set && !req.wr && !rsp.busy;
   rd_answer_a: assert property (rd_ok |=> rsp.rvalid) else $error("no data");
   busy_rd_a: assert property (req.rd && rsp.busy |=> !rsp.rvalid) else $error("busy");
   data_cause_a: assert property (rsp.rvalid |-> $past(rd_ok)) else $error("stray");
   data_hold_a: assert property (!rsp.rvalid |-> $stable(rsp.rdata)) else $error("hold");
   drive_hold_a: assert property ($stable(io_oe_n) || $past(req.wr, 2))
      else $error("drive");
   pullup_hold_a: assert property ($stable(pullup_en) || $past(req.wr, 2))
      else $error("pullup");
   busy_cause_a: assert property ($rose(rsp.busy) |-> $past(req.stop)) else $error("why");
   busy_span_a: assert property ($rose(rsp.busy) |-> ##BUSY_LAST rsp.busy ##1 !rsp.busy)
      else $error("span");
   cover property ($rose(rsp.busy));
   cover property (rsp.rvalid && rsp.rdata == 8'ha5);
   cover property ($changed(io_oe_n));
endmodule
bind nvx_regmap nvx_regmap_properties #(.TWR_CYC(TWR_CYC)) u_props (.clk(clk), .rstn(rstn),
   .req(req), .rsp(rsp), .io_oe_n(io_oe_n), .pullup_en(pullup_en));

// *** bench/nvx_host.sv ***
// Purpose: Bus master stand-in for the register map.
// Assumes: Falling-edge launch. Notes: Waits out busy.
`timescale 1ns/10ps
module nvx_host (
   input  wire logic         clk,
   input  wire logic         busy,
   output nvx_pkg::nvx_req_t req);
   initial req = '0;
   task automatic send(input logic [3:0] kind, input logic [7:0] data);
      @(negedge clk);
      while (busy !== 1'b0) @(negedge clk);
      req <= {kind, data};
      @(negedge clk);
      req <= '0;
   endtask
endmodule

// *** bench/nvx_regmap_tb.sv ***
// Purpose: Self-checking bench for the register map.
// Assumes: Short commit time. Notes: Each access ends in a stop.
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
   $display("unexpected %s expected %h seen %h", n, e, s); end end
module nvx_regmap_tb;
   import nvx_pkg::*;
   logic [8:0] io_in = 9'h15a, io_oe_n, pullup_en;
   logic       clk = 1'b0, rstn = 1'b0;
   nvx_req_t   req;
   nvx_rsp_t   rsp;
   int         mismatches = 0, n_compared = 0;
   nvx_host u_host (.clk(clk), .busy(rsp.busy), .req(req));
   nvx_regmap #(.TWR_CYC(20)) dut (.clk(clk), .rstn(rstn), .req(req), .rsp(rsp),
      .io_in(io_in), .io_out(), .io_oe_n(io_oe_n), .pullup_en(pullup_en));
   initial forever #5 clk = ~clk;
   task automatic acc(input logic [7:0] a, input logic [7:0] d[$], input logic r);
      u_host.send(4'h8, a);
      foreach (d[i]) begin
         u_host.send(r ? 4'h2 : 4'h4, d[i]);
         @(negedge clk);
         if (r) `CHK("read", d[i], rsp.rdata)
      end
      u_host.send(4'h1, 8'h00);
      @(negedge clk);
   endtask
   task automatic t_regs();
      acc(8'hf0, '{8'h00, 8'h00, 8'hff, 8'h01, 8'h00, 8'h00}, 1);
      acc(8'hf0, '{8'ha5, 8'h01, 8'h3c, 8'h00}, 0);
      `CHK("pins", {1'b1, 9'h1a5, 9'h03c}, {rsp.busy, pullup_en, io_oe_n})
      acc(8'hf4, '{8'h01, 8'h5e}, 0);
      acc(8'hf2, '{8'h0f}, 0);
      `CHK("see", {1'b0, 9'h00f}, {rsp.busy, io_oe_n})
      acc(8'hf4, '{8'h01, 8'h5e}, 1);
   endtask
   task automatic t_mem();
      acc(8'hfe, '{8'hc3, 8'h96}, 0);
      `CHK("busy", 1'b0, rsp.busy)
      acc(8'hfe, '{8'hc3, 8'h96, 8'h00}, 1);
      acc(8'h06, '{8'h11, 8'h22, 8'h33}, 0);
      acc(8'h06, '{8'h11, 8'h22}, 1);
      acc(8'h00, '{8'h33}, 1);
      io_in = 9'h0a5;
      acc(8'hf8, '{8'h00, 8'h00}, 0);
      acc(8'h40, '{8'h77}, 0);
      acc(8'hf8, '{8'ha5, 8'h00}, 1);
      acc(8'h40, '{8'h00}, 1);
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rstn = 1'b1;
      t_regs();
      t_mem();
      end_of_test();
   end
   initial begin
      #50000 mismatches++;
      end_of_test();
   end
   task automatic end_of_test();
      $display("compared %0d mismatched %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
endmodule
